// file: rtl/el_params.svh
// Offsets, field positions, reset values and timing counts of the EL shift driver.
// Assumes a 25 MHz aclk and a 32-bit AXI4-Lite register slave with 8 address bits in use.
// Behaviour
// R01 - The row register is 32 stages and shifts its serial input on each falling shift clock edge.
// R02 - A row stage holding one turns its row output on, pulling that row low; a zero leaves it off.
// R03 - The row enable and strobe together gate all 32 row outputs on or off at once.
// R04 - The last row stage appears on the row serial output for chaining.
// R05 - The controller should walk a single one through the rows and time each row with the enable.
// R06 - The column register is 32 stages and shifts its serial input on each rising shift clock edge.
// R07 - A latched one turns its column output on, sourcing; a latched zero keeps it pulled low.
// R08 - The last column stage appears on the column serial output for cascading.
// R09 - A 32-bit holding latch keeps the shown column pattern steady while new data shifts in.
// R10 - A falling latch enable edge copies the column register into the latch, held until the next one.
// R11 - A low column enable forces all column outputs low; a high one lets them follow the latch.
// R12 - Each row output is its stage ANDed with enable and strobe, both taken as active high.
`ifndef EL_PARAMS_SVH
`define EL_PARAMS_SVH

// ====================================================================
// Register map
`define EL_CTRL_OFS 8'h00
`define EL_ROW_SHIFT_OFS 8'h04
`define EL_COL_DATA_OFS 8'h08
`define EL_STATUS_OFS 8'h0C
`define EL_ROW_STATE_OFS 8'h10
`define EL_COL_SHIFT_OFS 8'h14
`define EL_COL_LATCH_OFS 8'h18

// ====================================================================
// Control fields and reset value
`define EL_CTRL_ROW_SW 0
`define EL_CTRL_COL_SW 1
`define EL_CTRL_ROW_OE 2
`define EL_CTRL_ROW_STROBE 3
`define EL_CTRL_COL_OE 4
`define EL_CTRL_RST 5'h00

// ====================================================================
// Status fields
`define EL_STAT_BUSY 8

// ====================================================================
// Sizes and timing
`define EL_STAGES 32
`define EL_FIFO_DEPTH 16
`define EL_CLK_NS 40
`define EL_SHIFT_NS 200
`define EL_SHIFT_CYC ((`EL_SHIFT_NS + `EL_CLK_NS - 1) / `EL_CLK_NS)
`define EL_RESP_OKAY 2'h0
`define EL_RESP_SLVERR 2'h2

`endif

// file: rtl/el_pkg.sv
// Types shared by the EL shift driver files.
// Assumes el_params.svh supplies the sizes.
`include "el_params.svh"
package el_pkg;

	// ====================================================================
	// Pin groups from the scan controller
	typedef struct packed {
		logic sclk;
		logic sdin;
		logic oe;
		logic strobe;
	} row_pins_t;

	typedef struct packed {
		logic sclk;
		logic sdin;
		logic le;
		logic oe;
	} col_pins_t;

	typedef logic [`EL_STAGES-1:0] stage_vec_t;

	typedef enum logic [2:0] {
		ENG_IDLE = 3'b001,
		ENG_SHIFT = 3'b010,
		ENG_LATCH = 3'b100
	} eng_state_t;

endpackage

// file: rtl/el_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module el_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	// Fill level
	output logic [$clog2(DEPTH):0] count
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;

	assign in_ready = (count_r != DEPTH[AW:0]);
	assign out_valid = (count_r != '0);
	assign out_data = mem[rd_ptr_r];
	assign count = count_r;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge aclk)
	begin
		if (push)
			mem[wr_ptr_r] <= in_data;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= rd_ptr_r + 1'b1;
			if (push && !pop)
				count_r <= count_r + 1'b1;
			else if (pop && !push)
				count_r <= count_r - 1'b1;
		end
	end
endmodule

// file: rtl/el_row_column_shift_driver.sv
// Row and column shift driver logic for an EL display, with an AXI4-Lite register slave.
// Assumes all pin inputs are synchronous to aclk; pin shift clocks are edge-detected on aclk.
`timescale 1ns/1ps
`include "el_params.svh"
module el_row_column_shift_driver
	import el_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	// AXI4-Lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	// AXI4-Lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Row driver pins
	input wire row_pins_t row_pins,
	output logic [`EL_STAGES-1:0] row_out_n,
	output logic row_sdout,
	// Column driver pins
	input wire col_pins_t col_pins,
	output logic [`EL_STAGES-1:0] col_out,
	output logic col_sdout
);

	// ====================================================================
	// Helpers
	function automatic logic fell(input logic prev, input logic cur);
		fell = prev && !cur;
	endfunction

	function automatic logic rose(input logic prev, input logic cur);
		rose = !prev && cur;
	endfunction

	function automatic logic mapped(input logic [7:0] addr);
		mapped = (addr == `EL_CTRL_OFS) || (addr == `EL_ROW_SHIFT_OFS) ||
			(addr == `EL_COL_DATA_OFS) || (addr == `EL_STATUS_OFS) ||
			(addr == `EL_ROW_STATE_OFS) || (addr == `EL_COL_SHIFT_OFS) ||
			(addr == `EL_COL_LATCH_OFS);
	endfunction

	localparam logic [3:0] SHIFT_LAST = 4'(`EL_SHIFT_CYC - 1);

	// ====================================================================
	// Declarations
	logic aw_held_r, w_held_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r, wr_ready_pair, wr_fire;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r, rdata_r, eng_word_r, fifo_out_data;
	logic [4:0] ctrl_r, eng_cnt_r, fifo_count;
	logic [3:0] w_strb_r, div_cnt_r;
	logic [1:0] bresp_r, rresp_r;
	stage_vec_t row_sr_r, row_out_n_r, col_sr_r, col_latch_r, col_out_r;
	logic row_sw, row_prev_sclk_r, row_shift_en, row_bit, row_gate, tick_r;
	logic col_sw, col_prev_sclk_r, col_prev_le_r, col_shift_en, col_bit, col_latch_en, col_oe;
	logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
	eng_state_t eng_r;

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign row_out_n = row_out_n_r;
	assign col_out = col_out_r;

	// ====================================================================
	// Write channel: address and data are taken in either order
	assign wr_ready_pair = aw_held_r && w_held_r && !bvalid_r;
	assign fifo_in_valid = wr_ready_pair && (aw_addr_r == `EL_COL_DATA_OFS);
	assign wr_fire = wr_ready_pair && ((aw_addr_r != `EL_COL_DATA_OFS) || fifo_in_ready);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r <= 1'b0;
			awready_r <= 1'b1;
			aw_addr_r <= 8'h00;
		end
		else if (s_axi_awvalid && awready_r)
		begin
			aw_held_r <= 1'b1;
			awready_r <= 1'b0;
			aw_addr_r <= s_axi_awaddr;
		end
		else if (wr_fire)
		begin
			aw_held_r <= 1'b0;
			awready_r <= 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held_r <= 1'b0;
			wready_r <= 1'b1;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
		end
		else if (s_axi_wvalid && wready_r)
		begin
			w_held_r <= 1'b1;
			wready_r <= 1'b0;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end
		else if (wr_fire)
		begin
			w_held_r <= 1'b0;
			wready_r <= 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_r <= 1'b0;
			bresp_r <= `EL_RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_r <= 1'b1;
			bresp_r <= mapped(aw_addr_r) ? `EL_RESP_OKAY : `EL_RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_r <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl_r <= `EL_CTRL_RST;
		else if (wr_fire && aw_addr_r == `EL_CTRL_OFS && w_strb_r[0])
			ctrl_r <= w_data_r[4:0];
	end

	assign row_sw = ctrl_r[`EL_CTRL_ROW_SW];
	assign col_sw = ctrl_r[`EL_CTRL_COL_SW];

	// ====================================================================
	// Read channel: data one cycle after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= `EL_RESP_OKAY;
		end
		else if (s_axi_arvalid && arready_r)
		begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rresp_r <= mapped(s_axi_araddr) ? `EL_RESP_OKAY : `EL_RESP_SLVERR;
			case (s_axi_araddr)
				`EL_CTRL_OFS: rdata_r <= {27'h0000000, ctrl_r};
				`EL_STATUS_OFS: rdata_r <= {23'h000000, eng_r != ENG_IDLE, 3'h0, fifo_count};
				`EL_ROW_STATE_OFS: rdata_r <= row_sr_r;
				`EL_COL_SHIFT_OFS: rdata_r <= col_sr_r;
				`EL_COL_LATCH_OFS: rdata_r <= col_latch_r;
				default: rdata_r <= 32'h00000000;
			endcase
		end
		else if (rvalid_r && s_axi_rready)
		begin
			rvalid_r <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	// ====================================================================
	// Row driver
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			row_prev_sclk_r <= 1'b0;
		else
			row_prev_sclk_r <= row_pins.sclk;
	end

	// R01 falling edge shift
	assign row_shift_en = row_sw ? (wr_fire && aw_addr_r == `EL_ROW_SHIFT_OFS) :
		fell(row_prev_sclk_r, row_pins.sclk);
	assign row_bit = row_sw ? w_data_r[0] : row_pins.sdin;
	// R03 common gate
	assign row_gate = row_sw ? (ctrl_r[`EL_CTRL_ROW_OE] && ctrl_r[`EL_CTRL_ROW_STROBE]) :
		(row_pins.oe && row_pins.strobe);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			row_sr_r <= '0;
		else if (row_shift_en)
			row_sr_r <= {row_sr_r[`EL_STAGES-2:0], row_bit};
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			row_out_n_r <= '1;
		else
			// R02 R12 stage one pulls low
			row_out_n_r <= ~(row_sr_r & {`EL_STAGES{row_gate}});
	end

	// R04 row chain output
	assign row_sdout = row_sr_r[`EL_STAGES-1];

	// ====================================================================
	// Software shift rate divider
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			div_cnt_r <= 4'h0;
			tick_r <= 1'b0;
		end
		else if (div_cnt_r == SHIFT_LAST)
		begin
			div_cnt_r <= 4'h0;
			tick_r <= 1'b1;
		end
		else
		begin
			div_cnt_r <= div_cnt_r + 4'h1;
			tick_r <= 1'b0;
		end
	end

	// ====================================================================
	// Column feed engine: FIFO words shifted out MSB first, then latched
	assign fifo_out_ready = col_sw && (eng_r == ENG_IDLE);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			eng_r <= ENG_IDLE;
			eng_word_r <= 32'h00000000;
			eng_cnt_r <= 5'h00;
		end
		else
		begin
			case (eng_r)
				ENG_IDLE:
				begin
					if (fifo_out_valid && fifo_out_ready)
					begin
						eng_word_r <= fifo_out_data;
						eng_cnt_r <= 5'h00;
						eng_r <= ENG_SHIFT;
					end
				end
				ENG_SHIFT:
				begin
					if (tick_r)
					begin
						eng_word_r <= {eng_word_r[30:0], 1'b0};
						eng_cnt_r <= eng_cnt_r + 5'h01;
						if (eng_cnt_r == 5'h1F)
							eng_r <= ENG_LATCH;
					end
				end
				ENG_LATCH:
					eng_r <= ENG_IDLE;
				default:
					eng_r <= ENG_IDLE;
			endcase
		end
	end

	// ====================================================================
	// Column driver
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			col_prev_sclk_r <= 1'b0;
			col_prev_le_r <= 1'b0;
		end
		else
		begin
			col_prev_sclk_r <= col_pins.sclk;
			col_prev_le_r <= col_pins.le;
		end
	end

	// R06 rising edge shift
	assign col_shift_en = col_sw ? (eng_r == ENG_SHIFT && tick_r) :
		rose(col_prev_sclk_r, col_pins.sclk);
	assign col_bit = col_sw ? eng_word_r[31] : col_pins.sdin;
	// R10 latch on falling edge
	assign col_latch_en = col_sw ? (eng_r == ENG_LATCH) : fell(col_prev_le_r, col_pins.le);
	assign col_oe = col_sw ? ctrl_r[`EL_CTRL_COL_OE] : col_pins.oe;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			col_sr_r <= '0;
		else if (col_shift_en)
			col_sr_r <= {col_sr_r[`EL_STAGES-2:0], col_bit};
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			col_latch_r <= '0;
		// R09 holding latch
		else if (col_latch_en)
			col_latch_r <= col_sr_r;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			col_out_r <= '0;
		else
			// R07 R11 enable forces low
			col_out_r <= col_oe ? col_latch_r : '0;
	end

	// R08 column chain output
	assign col_sdout = col_sr_r[`EL_STAGES-1];

	// ====================================================================
	// Column data FIFO; a full FIFO holds the write response back
	el_fifo #(
		.WIDTH(32),
		.DEPTH(`EL_FIFO_DEPTH)
	) u_fifo (
		.aclk(aclk),
		.aresetn(aresetn),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(w_data_r),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data),
		.count(fifo_count)
	);
endmodule

// file: test/el_row_column_shift_driver_monitor.sv
// Port checker for the EL shift driver, bound into its top module.
// Assumes each side stays in pin mode until software mode is set for that side.
`timescale 1ns/1ps
`include "el_params.svh"
module el_row_column_shift_driver_monitor
	import el_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Driver pins
	input wire row_pins_t row_pins,
	input wire logic [`EL_STAGES-1:0] row_out_n,
	input wire logic row_sdout,
	input wire col_pins_t col_pins,
	input wire logic [`EL_STAGES-1:0] col_out,
	input wire logic col_sdout
);
	// ====================================================================
	// Shadow registers
	logic [2:0] pv_r;
	logic [31:0] rs_r, cs_r, cl_r;
	logic sw_r, rsw_r, ctl_wr, rf, cr, lf;
	assign rf = pv_r[2] & !row_pins.sclk;
	assign cr = !pv_r[1] & col_pins.sclk;
	assign lf = pv_r[0] & !col_pins.le;
	always_ff @(posedge aclk)
		pv_r <= {row_pins.sclk, col_pins.sclk, col_pins.le};
	always_ff @(posedge aclk)
		rs_r <= !aresetn ? '0 : rf ? {rs_r[30:0], row_pins.sdin} : rs_r;
	always_ff @(posedge aclk)
		cs_r <= !aresetn ? '0 : cr ? {cs_r[30:0], col_pins.sdin} : cs_r;
	always_ff @(posedge aclk)
		cl_r <= !aresetn ? '0 : lf ? cs_r : cl_r;
	// Software mode on either side ends the pin checks on that side.
	assign ctl_wr = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready & s_axi_awaddr == `EL_CTRL_OFS;
	always_ff @(posedge aclk)
		sw_r <= aresetn & (sw_r | (ctl_wr & s_axi_wdata[`EL_CTRL_COL_SW]));
	always_ff @(posedge aclk)
		rsw_r <= aresetn & (rsw_r | (ctl_wr & s_axi_wdata[`EL_CTRL_ROW_SW]));
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ====================================================================
	// Assertions
	property p_row_stage;
		!rsw_r |-> row_sdout == rs_r[31];
	endproperty
	a_row_stage: assert property (p_row_stage) else $error("row serial out wrong");
	property p_row_out;
		!rsw_r |-> row_out_n == ~($past(rs_r) & {32{$past(row_pins.oe) & $past(row_pins.strobe)}});
	endproperty
	a_row_out: assert property (p_row_out) else $error("row outputs wrong");
	property p_col_stage;
		!sw_r |-> col_sdout == cs_r[31];
	endproperty
	a_col_stage: assert property (p_col_stage) else $error("column serial out wrong");
	property p_col_out;
		!sw_r |-> col_out == ($past(cl_r) & {32{$past(col_pins.oe)}});
	endproperty
	a_col_out: assert property (p_col_out) else $error("column outputs wrong");
	property p_b_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			&& s_axi_awaddr != `EL_COL_DATA_OFS |-> ##2 s_axi_bvalid;
	endproperty
	a_b_lat: assert property (p_b_lat) else $error("write response late");
	property p_b_once;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_once: assert property (p_b_once) else $error("write response repeated");
	property p_r_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_r_lat: assert property (p_r_lat) else $error("read data late");
	property p_r_once;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
	endproperty
	a_r_once: assert property (p_r_once) else $error("read data repeated");
endmodule
bind el_row_column_shift_driver el_row_column_shift_driver_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .row_pins, .row_out_n, .row_sdout,
	.col_pins, .col_out, .col_sdout);

// file: test/el_scan_ctl_model.sv
// Scan controller model driving the row and column pins.
// Assumes pins are sampled on aclk, so each clock level is held two cycles.
`timescale 1ns/1ps
module el_scan_ctl_model
	import el_pkg::*;
(
	// Clock
	input wire logic aclk,
	// Pins
	output row_pins_t row_pins,
	output col_pins_t col_pins
);
	initial
	begin
		row_pins = '0;
		col_pins = '0;
	end
	task automatic row_bit(input logic b);
	begin
		@(posedge aclk);
		row_pins.sdin <= b;
		row_pins.sclk <= 1'b1;
		repeat (2) @(posedge aclk);
		row_pins.sclk <= 1'b0;
		@(posedge aclk);
		row_pins.sdin <= ~b;
	end
	endtask
	task automatic col_bit(input logic b);
	begin
		@(posedge aclk);
		col_pins.sdin <= b;
		@(posedge aclk);
		col_pins.sclk <= 1'b1;
		repeat (2) @(posedge aclk);
		col_pins.sclk <= 1'b0;
		col_pins.sdin <= ~b;
	end
	endtask
	task automatic col_word(input logic [31:0] w);
		for (int i = 31; i >= 0; i--)
			col_bit(w[i]);
	endtask
	task automatic col_latch;
	begin
		@(posedge aclk);
		col_pins.le <= 1'b1;
		repeat (2) @(posedge aclk);
		col_pins.le <= 1'b0;
	end
	endtask
	task automatic gates(input logic roe, input logic rst, input logic coe);
	begin
		@(posedge aclk);
		row_pins.oe <= roe;
		row_pins.strobe <= rst;
		col_pins.oe <= coe;
	end
	endtask
endmodule

// file: test/el_row_column_shift_driver_tb.sv
// Self-checking bench for the EL shift driver.
// Assumes the scan controller model drives the pins and this bench is the bus master.
`timescale 1ns/1ps
`include "el_params.svh"
module el_row_column_shift_driver_tb;
	import el_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, row_sdout, col_sdout;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, row_out_n, col_out, d, w;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [3:0] s_axi_wstrb;
	row_pins_t row_pins;
	col_pins_t col_pins;
	int fails, n_tests, seed;
	el_row_column_shift_driver u_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
		.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
		.s_axi_rready, .s_axi_rdata, .s_axi_rresp, .row_pins, .row_out_n, .row_sdout, .col_pins, .col_out,
		.col_sdout);
	el_scan_ctl_model u_ctl (.aclk, .row_pins, .col_pins);
	initial
	begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	// ====================================================================
	// Tasks
	function automatic logic [31:0] row_exp(input logic [31:0] st, input logic g);
		return ~(st & {32{g}});
	endfunction
	function automatic logic [31:0] col_exp(input logic [31:0] v, input logic oe);
		return v & {32{oe}};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
	begin
		n_tests++;
		if (g !== e)
		begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	end
	endtask
	task automatic settle;
	begin
		repeat (3) @(posedge aclk);
		#1;
	end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
	begin
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		r = s_axi_bresp;
	end
	endtask
	task automatic axr(input logic [7:0] a);
	begin
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	end
	endtask
	task automatic tally_and_finish;
	begin
		$display("checks=%0d mismatches=%0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask
	initial
	begin
		repeat (20000) @(posedge aclk);
		fails++;
		tally_and_finish;
	end
	// ====================================================================
	// Tests
	initial
	begin
		seed = 32'h0A137036;
		fails = 0;
		n_tests = 0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		settle;
		chk(row_out_n, 32'hFFFFFFFF);
		chk(col_out, 32'h0);
		$display("test reset done");
		u_ctl.gates(1'b1, 1'b1, 1'b1);
		for (int i = 0; i < 33; i++)
		begin
			u_ctl.row_bit(i == 0);
			settle;
			chk(row_out_n, row_exp(32'h1 << i, 1'b1));
			chk(row_sdout, i == 31);
		end
		w = $random(seed);
		for (int i = 31; i >= 0; i--)
			u_ctl.row_bit(w[i]);
		for (int g = 0; g < 4; g++)
		begin
			u_ctl.gates(g[0], g[1], 1'b1);
			settle;
			chk(row_out_n, row_exp(w, g == 3));
		end
		chk(row_sdout, w[31]);
		$display("test row done");
		w = $random(seed);
		u_ctl.col_word(w);
		u_ctl.col_latch;
		settle;
		chk(col_out, col_exp(w, 1'b1));
		chk(col_sdout, w[31]);
		d = $random(seed);
		u_ctl.col_word(d);
		settle;
		chk(col_out, col_exp(w, 1'b1));
		u_ctl.gates(1'b1, 1'b1, 1'b0);
		settle;
		chk(col_out, col_exp(w, 1'b0));
		u_ctl.col_latch;
		u_ctl.gates(1'b1, 1'b1, 1'b1);
		settle;
		chk(col_out, col_exp(d, 1'b1));
		$display("test column done");
		axw(8'h40, 32'h1);
		chk(r, `EL_RESP_SLVERR);
		axr(8'h40);
		chk(r, `EL_RESP_SLVERR);
		chk(d, 32'h0);
		axw(`EL_STATUS_OFS, 32'hFFFF);
		chk(r, `EL_RESP_OKAY);
		axw(`EL_CTRL_OFS, 32'h1C);
		axr(`EL_CTRL_OFS);
		chk(d, 32'h1C);
		s_axi_wstrb <= 4'hE;
		axw(`EL_CTRL_OFS, 32'h0);
		s_axi_wstrb <= 4'hF;
		axr(`EL_CTRL_OFS);
		chk(d, 32'h1C);
		$display("test registers done");
		axw(`EL_CTRL_OFS, 32'h12);
		for (int i = 0; i < 17; i++)
		begin
			w = $random(seed);
			axw(`EL_COL_DATA_OFS, w);
		end
		axr(`EL_STATUS_OFS);
		chk(d[4:0], 5'h10);
		chk(d[8], 1'b1);
		w = $random(seed);
		axw(`EL_COL_DATA_OFS, w);
		do axr(`EL_STATUS_OFS); while (d[8] || d[4:0] != 5'h00);
		axr(`EL_COL_LATCH_OFS);
		chk(d, w);
		chk(col_out, col_exp(w, 1'b1));
		axr(`EL_COL_SHIFT_OFS);
		chk(d, w);
		chk(col_sdout, w[31]);
		$display("test fifo done");
		axw(`EL_CTRL_OFS, 32'h1F);
		w = $random(seed);
		for (int i = 31; i >= 0; i--)
			axw(`EL_ROW_SHIFT_OFS, {31'h0, w[i]});
		axr(`EL_ROW_STATE_OFS);
		chk(d, w);
		chk(row_out_n, row_exp(w, 1'b1));
		chk(row_sdout, w[31]);
		axw(`EL_CTRL_OFS, 32'h17);
		settle;
		chk(row_out_n, row_exp(w, 1'b0));
		$display("test row software done");
		tally_and_finish;
	end
endmodule
